// ===== ocfs_map.svh
// Purpose: register offsets, field positions and reset values
// Assumes: 16-bit registers, byte-sized word addresses
// Notes:   definitions only
`ifndef OCFS_MAP_SVH
`define OCFS_MAP_SVH
`define OCFS_ADDR_W            8
`define OCFS_DATA_W            16
`define OCFS_OFS_SPREAD_CTRL   8'h2D
`define OCFS_OFS_SUPPLY_SEL    8'h2E
`define OCFS_OFS_FRAC_UPPER    8'h2F
`define OCFS_OFS_FRAC_LOWER    8'h30
`define OCFS_RST_SPREAD_CTRL   16'h0071
`define OCFS_RST_SUPPLY_SEL    16'h0008
`define OCFS_RST_FRAC_UPPER    16'h8000
`define OCFS_RST_FRAC_LOWER    16'h0000
`define OCFS_BIT_DELAY         15
`define OCFS_BIT_BYPASS        14
`define OCFS_BIT_DIV_RST       13
`define OCFS_BIT_CNT_SRC       12
`define OCFS_CNT_DIV_HI        11
`define OCFS_CNT_DIV_LO        9
`define OCFS_BIT_PROFILE       8
`define OCFS_DEPTH_HI          7
`define OCFS_DEPTH_LO          6
`define OCFS_PERIOD_HI         5
`define OCFS_PERIOD_LO         4
`define OCFS_BIT_SPREAD_EN     3
`define OCFS_BIT_SMOOTH        0
`define OCFS_BIT_LOW_SUPPLY    3
`define OCFS_FRAC_LOWER_W      9
`define OCFS_FRAC_W            25
`define OCFS_PERIOD_C0         10'd240
`define OCFS_PERIOD_C1         10'd400
`define OCFS_PERIOD_C2         10'd520
`define OCFS_PERIOD_C3         10'd556
`endif

// ===== ocfs_pkg.sv
// Purpose: types for the channel fractional divider register bank
// Assumes: nothing
// Notes:   profile encoding follows bit 8; divider mode codes are 1 (synthesis) and 2 (delay), not the bit 15 value
package ocfs_pkg;
	typedef enum logic [1:0] {
		OCFS_DIV_SYNTH  = 2'h1,
		OCFS_DIV_DELAY  = 2'h2
	} ocfs_div_mode_t;
	typedef enum logic {
		OCFS_PROF_CENTER = 1'b0,
		OCFS_PROF_DOWN   = 1'b1
	} ocfs_profile_t;
endpackage

// ===== ocfs_regs.sv
// Purpose: channel 2 divider/spread control, supply select, channel 3 fraction
// Assumes: serial host front end delivers decoded word writes and reads
// Notes:   all fields read back as written, reserved bits included
//Contract
//R1: bit 15 picks delay or synthesis mode
//R2: bit 14 bypasses divider register stages
//R3: bit 13 holds divider in reset
//R4: bit 12 picks spread counter clock
//R5: bits 11-9 divide spread counter clock
//R6: bit 8 picks center or down spread
//R7: bits 7-6 set modulation depth
//R8: bits 5-4 set cycles per modulation period
//R9: bit 3 enables spread modulation
//R10: bit 0 picks immediate or glitchless changes
//R11: supply bit 3 selects 1.8 V, reset one
//R12: upper fraction 16 bits, reset 8000h
//R13: lower fraction 9 bits, reset zero
//R14: fraction also feeds delay mode
//R15: control register resets to 71h
//R16: upper field forms fraction most significant part
`timescale 1ns/1ns
`include "ocfs_map.svh"
module ocfs_regs
	import ocfs_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// Register port from the serial host
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [`OCFS_ADDR_W-1:0]   reg_addr,
	input  wire logic [`OCFS_DATA_W-1:0]   reg_wdata,
	output logic      [`OCFS_DATA_W-1:0]   reg_rdata,
	output logic                           reg_hit,
	// Divider controls
	output logic                           ch2_divider_delay_select,
	output ocfs_div_mode_t                 ch2_divider_mode,
	output logic                           ch2_divider_bypass,
	output logic                           ch2_divider_reset,
	output logic                           ch2_spread_counter_clock_sel,
	output logic      [2:0]                ch2_spread_counter_div,
	output ocfs_profile_t                  ch2_spread_profile,
	output logic      [1:0]                ch2_spread_depth,
	output logic      [9:0]                ch2_spread_period_cycles,
	output logic                           ch2_spread_enable,
	output logic                           ch2_smooth_switch_enable,
	output logic                           ch2_low_supply_select,
	// Fraction for channel 3
	output logic      [15:0]               ch3_fraction_upper_field,
	output logic      [`OCFS_FRAC_LOWER_W-1:0] ch3_fraction_lower_field,
	output logic      [`OCFS_FRAC_W-1:0]   ch3_synth_fraction,
	output logic      [`OCFS_FRAC_W-1:0]   ch3_delay_fraction
);
	logic [`OCFS_DATA_W-1:0] ctrl_ff;
	logic [`OCFS_DATA_W-1:0] supply_ff;
	logic [`OCFS_DATA_W-1:0] frac_hi_ff;
	logic [`OCFS_DATA_W-1:0] frac_lo_ff;
	logic [`OCFS_DATA_W-1:0] rdata_ff;
	logic                    hit_ff;
	logic [`OCFS_DATA_W-1:0] nxt_rdata;
	logic [`OCFS_FRAC_W-1:0] frac_all;

	wire sel_ctrl   = (reg_addr == `OCFS_OFS_SPREAD_CTRL);
	wire sel_supply = (reg_addr == `OCFS_OFS_SUPPLY_SEL);
	wire sel_hi     = (reg_addr == `OCFS_OFS_FRAC_UPPER);
	wire sel_lo     = (reg_addr == `OCFS_OFS_FRAC_LOWER);
	wire sel_any    = sel_ctrl | sel_supply | sel_hi | sel_lo;

	// Unmapped reads return zero
	assign nxt_rdata = sel_ctrl   ? ctrl_ff :
	                   sel_supply ? supply_ff :
	                   sel_hi     ? frac_hi_ff :
	                   sel_lo     ? frac_lo_ff : 16'h0000;

	// Period code to cycle count
	function automatic logic [9:0] period_of(input logic [1:0] code);
		case (code)
			2'h0: period_of = `OCFS_PERIOD_C0;
			2'h1: period_of = `OCFS_PERIOD_C1;
			2'h2: period_of = `OCFS_PERIOD_C2;
			default: period_of = `OCFS_PERIOD_C3;
		endcase
	endfunction

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_ff    <= `OCFS_RST_SPREAD_CTRL; // R15
			supply_ff  <= `OCFS_RST_SUPPLY_SEL;  // R11
			frac_hi_ff <= `OCFS_RST_FRAC_UPPER;  // R12
			frac_lo_ff <= `OCFS_RST_FRAC_LOWER;  // R13
		end else if (reg_wr) begin
			if (sel_ctrl)
				ctrl_ff <= reg_wdata;
			if (sel_supply)
				supply_ff <= reg_wdata;
			if (sel_hi)
				frac_hi_ff <= reg_wdata;
			if (sel_lo)
				frac_lo_ff <= reg_wdata;
		end
	end

	// Read data registered, valid the cycle after reg_rd
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_ff <= 16'h0000;
			hit_ff   <= 1'b0;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
			hit_ff   <= sel_any;
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_hit   = hit_ff;

	assign ch2_divider_delay_select     = ctrl_ff[`OCFS_BIT_DELAY]; // R1
	assign ch2_divider_mode             = ctrl_ff[`OCFS_BIT_DELAY] ?
	                                      OCFS_DIV_DELAY : OCFS_DIV_SYNTH; // R1
	assign ch2_divider_bypass           = ctrl_ff[`OCFS_BIT_BYPASS]; // R2
	// Level held while the bit stays set
	assign ch2_divider_reset            = ctrl_ff[`OCFS_BIT_DIV_RST]; // R3
	assign ch2_spread_counter_clock_sel = ctrl_ff[`OCFS_BIT_CNT_SRC]; // R4
	assign ch2_spread_counter_div       = ctrl_ff[`OCFS_CNT_DIV_HI:`OCFS_CNT_DIV_LO]; // R5
	assign ch2_spread_profile           = ocfs_profile_t'(ctrl_ff[`OCFS_BIT_PROFILE]); // R6
	assign ch2_spread_depth             = ctrl_ff[`OCFS_DEPTH_HI:`OCFS_DEPTH_LO]; // R7
	assign ch2_spread_period_cycles     = period_of(ctrl_ff[`OCFS_PERIOD_HI:`OCFS_PERIOD_LO]); // R8
	assign ch2_spread_enable            = ctrl_ff[`OCFS_BIT_SPREAD_EN]; // R9
	assign ch2_smooth_switch_enable     = ctrl_ff[`OCFS_BIT_SMOOTH]; // R10
	assign ch2_low_supply_select        = supply_ff[`OCFS_BIT_LOW_SUPPLY]; // R11

	assign ch3_fraction_upper_field = frac_hi_ff; // R12
	assign ch3_fraction_lower_field = frac_lo_ff[`OCFS_FRAC_LOWER_W-1:0]; // R13
	assign frac_all = {frac_hi_ff, frac_lo_ff[`OCFS_FRAC_LOWER_W-1:0]}; // R16
	// Same fraction steers whichever mode is active; idle side reads zero
	assign ch3_synth_fraction = ctrl_ff[`OCFS_BIT_DELAY] ? '0 : frac_all;
	assign ch3_delay_fraction = ctrl_ff[`OCFS_BIT_DELAY] ? frac_all : '0; // R14
endmodule

// ===== ocfs_regs_properties.sv
// Purpose: timing checks on the register bank ports
// Assumes: one clock, reset active high
// Notes: bound to every instance
`timescale 1ns/1ns
module ocfs_regs_properties (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_hit,
	// Controls and fractions
	input wire logic        ch2_divider_delay_select,
	input wire logic [9:0]  ch2_spread_period_cycles,
	input wire logic        ch2_smooth_switch_enable,
	input wire logic        ch2_low_supply_select,
	input wire logic [15:0] ch3_fraction_upper_field,
	input wire logic [8:0]  ch3_fraction_lower_field,
	input wire logic [24:0] ch3_synth_fraction,
	input wire logic [24:0] ch3_delay_fraction
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic w_ctl = reg_wr && reg_addr == 8'h2D;
	wire logic [24:0] frac = {ch3_fraction_upper_field, ch3_fraction_lower_field};
	wire logic [1:0] pc = reg_wdata[5:4];
	wire logic [9:0] per = pc[1] ? (pc[0] ? 10'd556 : 10'd520) : (pc[0] ? 10'd400 : 10'd240);
	delay_bit_a: assert property (w_ctl |=> ch2_divider_delay_select == $past(reg_wdata[15]))
		else $error("delay bit");
	period_map_a: assert property (w_ctl |=> ch2_spread_period_cycles == $past(per))
		else $error("period");
	smooth_bit_a: assert property (w_ctl |=> ch2_smooth_switch_enable == $past(reg_wdata[0]))
		else $error("smooth bit");
	supply_bit_a: assert property (reg_wr && reg_addr == 8'h2E |=> ch2_low_supply_select == $past(reg_wdata[3]))
		else $error("supply bit");
	upper_field_a: assert property (reg_wr && reg_addr == 8'h2F |=> ch3_fraction_upper_field == $past(reg_wdata))
		else $error("upper");
	lower_field_a: assert property (reg_wr && reg_addr == 8'h30 |=> ch3_fraction_lower_field == $past(reg_wdata[8:0]))
		else $error("lower");
	delay_frac_a: assert property (ch2_divider_delay_select |-> ch3_delay_fraction == frac)
		else $error("delay fraction");
	synth_frac_a: assert property (!ch2_divider_delay_select |-> ch3_synth_fraction == frac && ch3_delay_fraction == 0)
		else $error("synth fraction");
	cover property (w_ctl ##1 ch2_divider_delay_select);
	cover property (reg_rd ##1 !reg_hit);
	cover property ($fell(sys_rst) ##[1:20] reg_rd);
endmodule
bind ocfs_regs ocfs_regs_properties u_props(.*);

// ===== ocfs_host.sv
// Purpose: serial host side, word writes and reads
// Assumes: one clock
// Notes: released lines show inverted values
`timescale 1ns/1ns
module ocfs_host (
	// Clock
	input wire logic    clk,
	// Register port
	output logic        reg_wr,
	output logic        reg_rd,
	output logic [7:0]  reg_addr,
	output logic [15:0] reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge clk);
		#1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge clk);
		#1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk);
		#1 {reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk);
		#1 {reg_rd, reg_addr} = {1'b0, ~a};
	endtask
endmodule

// ===== tb_ocfs_regs.sv
// Purpose: register bank self-check
// Assumes: host model drives the port
// Notes: second reset mid-run
`timescale 1ns/1ns
module tb_ocfs_regs
	import ocfs_pkg::*;
;
	logic clk = 0, sys_rst = 1, reg_hit, ch2_divider_delay_select, ch2_divider_bypass;
	logic ch2_divider_reset, ch2_spread_counter_clock_sel, ch2_spread_enable;
	logic ch2_smooth_switch_enable, ch2_low_supply_select, reg_wr, reg_rd;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, ch3_fraction_upper_field;
	logic [24:0] ch3_synth_fraction, ch3_delay_fraction;
	logic [9:0] ch2_spread_period_cycles;
	logic [8:0] ch3_fraction_lower_field;
	logic [2:0] ch2_spread_counter_div;
	logic [1:0] ch2_spread_depth;
	ocfs_div_mode_t ch2_divider_mode;
	ocfs_profile_t ch2_spread_profile;
	int n_errors = 0, comparisons = 0;
	ocfs_host HOST(.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	ocfs_regs DUT(.*);
	// Wide enough for both 25-bit fractions side by side
	task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd_chk(logic [7:0] a, logic [16:0] e);
		HOST.rd(a);
		chk("rdata", {reg_hit, reg_rdata}, e);
	endtask
	task automatic t_reset();
		rd_chk(8'h2D, 17'h10071);
		rd_chk(8'h2E, 17'h10008);
		rd_chk(8'h2F, 17'h18000);
		rd_chk(8'h30, 17'h10000);
		chk("period", ch2_spread_period_cycles, 556);
	endtask
	task automatic t_fields();
		logic [9:0] per [4] = '{240, 400, 520, 556};
		logic [15:0] w;
		for (int k = 0; k < 4; k++) begin
			w = (k[0] ? 16'hA109 : 16'h5006) | {4'h0, 3'(k), 1'b0, 2'(k), 2'(k), 4'h0};
			HOST.wr(8'h2D, w);
			chk("ctrl", {ch2_divider_delay_select, ch2_divider_bypass, ch2_divider_reset, ch2_spread_counter_clock_sel, ch2_spread_counter_div, ch2_spread_profile, ch2_spread_depth, ch2_spread_enable, ch2_smooth_switch_enable}, {k[0], !k[0], k[0], !k[0], 3'(k), k[0], 2'(k), k[0], k[0]});
			chk("mode", ch2_divider_mode, k[0] ? OCFS_DIV_DELAY : OCFS_DIV_SYNTH);
			chk("period", ch2_spread_period_cycles, per[k]);
			rd_chk(8'h2D, {1'b1, w});
		end
	endtask
	task automatic t_frac();
		HOST.wr(8'h2F, 16'h1234);
		HOST.wr(8'h30, 16'hFFFF);
		rd_chk(8'h30, 17'h1FFFF);
		chk("fields", {ch3_fraction_upper_field, ch3_fraction_lower_field}, 25'h02469FF);
		// Last field pattern left delay mode on; back to synthesis first
		HOST.wr(8'h2D, 16'h0000);
		chk("synth", {ch3_synth_fraction, ch3_delay_fraction}, {16'h1234, 9'h1FF, 25'h0});
		HOST.wr(8'h2D, 16'h8000);
		chk("delay", {ch3_delay_fraction, ch3_synth_fraction}, {16'h1234, 9'h1FF, 25'h0});
		HOST.wr(8'h2E, 16'h0000);
		chk("supply", ch2_low_supply_select, 0);
		rd_chk(8'h31, 17'h0);
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 sys_rst = 0;
		t_reset();
		t_fields();
		t_frac();
		sys_rst = 1;
		repeat (2) @(posedge clk);
		#1 sys_rst = 0;
		t_reset();
		report_and_stop();
	end
endmodule
